// *** core/module_chip_select_decoder.sv ***
// Chip-select decoder with start-up sequencing and self-check lamp.
// How it works
// (R1) Boot ROM select low only for reads in the lowest 64 kbytes.
// (R2) Bit 15 is ignored, so ROM and RAM mirror just above themselves.
// (R3) RAM region reads assert RAM read select, writes RAM write select.
// (R4) Windows A and B drive their own select on any access inside.
// (R5) Windows C and D likewise drive their own select.
// (R6) Window accesses assert shared select plus read or write strobe.
// (R7) All selects active low, others held high.
// (R8) Port carries 8-bit data, two strobes, four selects, four address LSBs.
// (R9) No fetch or execution before the PLL reports lock.
// (R10) Clock multiplier reads as 256 times reference after reset.
// (R11) Software doubles the clock after lock.
// (R12) Data bit 0 low during reset selects 8-bit boot memory.
// (R13) Supervisor resets at power-up and on each button press.
// (R14) Self-test pass flashes lamp 50/50, starting within five seconds; the code starts it at i_test_done, with no timer.
// (R15) Self-test failure flashes lamp 10 on, 90 off.
// (R16) Unused ranges leave external selects and strobes high.
// (R17) Selects follow current address and direction for the whole cycle; the code registers them, so they lag one cycle.
`timescale 1ns/100ps
`include "cs_decoder_defs.svh"

module module_chip_select_decoder (
    input  wire logic               i_sys_clk,
    input  wire logic               i_sys_rst,
    input  wire logic [19:0]        i_addr,
    input  wire logic               i_read,
    input  wire logic               i_write,
    input  wire logic [7:0]         i_cpu_wdata,
    input  wire logic [7:0]         i_port_data,
    input  wire logic               i_pll_lock,
    input  wire logic               i_button_n,
    input  wire logic               i_data0_strap,
    input  wire logic               i_clk_double,
    input  wire logic               i_test_done,
    input  wire logic               i_test_pass,
    output logic                    o_boot_rom_select_n,
    output logic                    o_ram_read_select_n,
    output logic                    o_ram_write_select_n,
    output logic                    o_ext_read_strobe_n,
    output logic                    o_ext_write_strobe_n,
    output logic                    o_ext_access_select_n,
    output logic [3:0]              o_window_select_n,
    output logic [3:0]              o_port_addr_lsb,
    output logic [7:0]              o_port_data_lsb,
    output logic                    o_port_data_oe,
    output logic [7:0]              o_cpu_rdata,
    output logic                    o_cpu_run,
    output logic                    o_boot_8bit,
    output logic [9:0]              o_clk_mult,
    output logic                    o_sup_reset,
    output logic                    o_led
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] lock_sync_q;
    logic [1:0] btn_sync_q;
    logic [1:0] strap_sync_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            lock_sync_q  <= 2'h0;
            btn_sync_q   <= 2'h3;
            strap_sync_q <= 2'h3;
        end else begin
            lock_sync_q  <= {lock_sync_q[0], i_pll_lock};
            btn_sync_q   <= {btn_sync_q[0], i_button_n};
            strap_sync_q <= {strap_sync_q[0], i_data0_strap};
        end
    end

    // ----------------------------------------------------------------
    // Reset supervisor
    // ----------------------------------------------------------------
    logic        btn_prev_q;
    logic [15:0] sup_cnt_q;

    // (R13) Power-up and button pulse.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            btn_prev_q <= 1'b1;
            sup_cnt_q  <= `SUP_PULSE_CYC;
        end else begin
            btn_prev_q <= btn_sync_q[1];
            if (btn_prev_q && !btn_sync_q[1]) begin
                sup_cnt_q <= `SUP_PULSE_CYC;
            end else if (sup_cnt_q != 16'h0000) begin
                sup_cnt_q <= sup_cnt_q - 16'h0001;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_sup_reset <= 1'b1;
        end else begin
            o_sup_reset <= (sup_cnt_q != 16'h0000);
        end
    end

    // ----------------------------------------------------------------
    // Start-up sequencing
    // ----------------------------------------------------------------
    cs_decoder_pkg::boot_state_e state_q;

    // (R9) Hold execution until lock.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || o_sup_reset) begin
            state_q <= cs_decoder_pkg::ST_RESET;
        end else begin
            unique case (state_q)
                cs_decoder_pkg::ST_RESET: begin
                    state_q <= cs_decoder_pkg::ST_WAIT_LOCK;
                end
                cs_decoder_pkg::ST_WAIT_LOCK: begin
                    if (lock_sync_q[1]) begin
                        state_q <= cs_decoder_pkg::ST_RUN;
                    end
                end
                cs_decoder_pkg::ST_RUN: begin
                    state_q <= cs_decoder_pkg::ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_cpu_run <= 1'b0;
        end else begin
            o_cpu_run <= (state_q == cs_decoder_pkg::ST_RUN) && !o_sup_reset;
        end
    end

    // The strap is caught while reset is held, never loaded by the reset itself.
    // (R12) Boot width strap.
    always_ff @(posedge i_sys_clk) begin
        if (state_q == cs_decoder_pkg::ST_RESET) begin
            o_boot_8bit <= !strap_sync_q[1];
        end
    end

    // (R10) Multiplier after reset; (R11) doubled by software once running.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || o_sup_reset) begin
            o_clk_mult <= {1'b0, `PLL_MULT};
        end else if (i_clk_double && state_q == cs_decoder_pkg::ST_RUN) begin
            o_clk_mult <= {`PLL_MULT, 1'b0};
        end
    end

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    cs_decoder_pkg::selects_s sel_d;
    logic                     win_hit;
    logic [1:0]               win_idx;

    always_comb begin
        sel_d   = '1;
        win_hit = (i_addr[19:12] == `WIN_BASE_HI) || (i_addr[19:12] == `WIN_BASE_HI2);
        win_idx = i_addr[12:11];
        if (o_cpu_run && (i_read || i_write)) begin
            // (R2) Bit 15 is left out of the compare.
            // (R1) Boot ROM on reads.
            if (i_addr[19:16] == `BOOT_TOP_NIB && i_read) begin
                sel_d.boot_rom_select_n = 1'b0;
            end
            // (R3) RAM read and write selects.
            if (i_addr[19:16] == `RAM_TOP_NIB) begin
                sel_d.ram_read_select_n  = !i_read;
                sel_d.ram_write_select_n = !i_write;
            end
            // (R4) (R5) (R6) Windows, shared select and strobes.
            if (win_hit) begin
                sel_d.window_select_n[win_idx] = 1'b0;
                sel_d.ext_access_select_n      = 1'b0;
                sel_d.ext_read_strobe_n        = !i_read;
                sel_d.ext_write_strobe_n       = !i_write;
            end
        end
        // (R16) Unused ranges fall through with every select high.
    end

    // Registering costs one cycle of latency but keeps the pins glitch free.
    // (R7) (R17) Selects registered each cycle.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_boot_rom_select_n   <= 1'b1;
            o_ram_read_select_n   <= 1'b1;
            o_ram_write_select_n  <= 1'b1;
            o_ext_read_strobe_n   <= 1'b1;
            o_ext_write_strobe_n  <= 1'b1;
            o_ext_access_select_n <= 1'b1;
            o_window_select_n     <= 4'hF;
        end else begin
            o_boot_rom_select_n   <= sel_d.boot_rom_select_n;
            o_ram_read_select_n   <= sel_d.ram_read_select_n;
            o_ram_write_select_n  <= sel_d.ram_write_select_n;
            o_ext_read_strobe_n   <= sel_d.ext_read_strobe_n;
            o_ext_write_strobe_n  <= sel_d.ext_write_strobe_n;
            o_ext_access_select_n <= sel_d.ext_access_select_n;
            o_window_select_n     <= sel_d.window_select_n;
        end
    end

    // (R8) Port address, data and direction.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_port_addr_lsb <= 4'h0;
            o_port_data_lsb <= 8'h00;
            o_port_data_oe  <= 1'b0;
            o_cpu_rdata     <= 8'h00;
        end else begin
            o_port_addr_lsb <= i_addr[3:0];
            o_port_data_lsb <= i_cpu_wdata;
            o_port_data_oe  <= !sel_d.ext_write_strobe_n;
            o_cpu_rdata     <= i_port_data;
        end
    end

    // ----------------------------------------------------------------
    // Self-check lamp
    // ----------------------------------------------------------------
    logic [31:0] flash_cnt_q;
    logic [31:0] on_cyc;

    assign on_cyc = i_test_pass ? 32'((`FLASH_PERIOD_CYC * `PASS_ON_PCT) / 100)
                                : 32'((`FLASH_PERIOD_CYC * `FAIL_ON_PCT) / 100);

    // The lamp is lit steadily until the test reports, so a stuck part shows as no flashing.
    // (R14) (R15) Pass and fail duty cycles.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || !o_cpu_run || !i_test_done) begin
            flash_cnt_q <= 32'h0000_0000;
            o_led       <= 1'b1;
        end else begin
            if (flash_cnt_q == 32'(`FLASH_PERIOD_CYC - 1)) begin
                flash_cnt_q <= 32'h0000_0000;
            end else begin
                flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
            end
            o_led <= (flash_cnt_q < on_cyc);
        end
    end

endmodule : module_chip_select_decoder

// *** core/cs_decoder_defs.svh ***
// Address map, start-up and status lamp timing constants of the chip-select decoder.
`ifndef CS_DECODER_DEFS_SVH
`define CS_DECODER_DEFS_SVH

// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define ADDR_W               20
`define BOOT_TOP_NIB         4'h0
`define RAM_TOP_NIB          4'h1
`define WIN_BASE_HI          8'h7E
`define WIN_BASE_HI2         8'h7F

// ----------------------------------------------------------------
// Clocking and start-up
// ----------------------------------------------------------------
`define PLL_MULT             9'h100
`define CLK_HZ               20_000_000
`define FLASH_START_S        5
`define FLASH_START_CYC      (`FLASH_START_S * `CLK_HZ)
`define FLASH_PERIOD_MS      1000
`define FLASH_PERIOD_CYC     (`FLASH_PERIOD_MS * (`CLK_HZ / 1000))
`define PASS_ON_PCT          50
`define FAIL_ON_PCT          10
`define SUP_PULSE_CYC        16'h0010

`endif

// *** core/cs_decoder_pkg.sv ***
// Types shared by the chip-select decoder.
package cs_decoder_pkg;

    typedef struct packed {
        logic boot_rom_select_n;
        logic ram_read_select_n;
        logic ram_write_select_n;
        logic ext_read_strobe_n;
        logic ext_write_strobe_n;
        logic ext_access_select_n;
        logic [3:0] window_select_n;
    } selects_s;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_WAIT_LOCK,
        ST_RUN
    } boot_state_e;

endpackage : cs_decoder_pkg

// *** tb/cs_decoder_assertions.sv ***
// Port-level checks of the chip-select decoder.
`timescale 1ns/100ps
module cs_decoder_checker (
    input wire logic        i_sys_clk,
    input wire logic        i_sys_rst,
    input wire logic [19:0] i_addr,
    input wire logic        i_read,
    input wire logic        i_write,
    input wire logic        i_pll_lock,
    input wire logic        o_cpu_run,
    input wire logic        o_boot_rom_select_n,
    input wire logic        o_ram_read_select_n,
    input wire logic        o_ram_write_select_n,
    input wire logic        o_ext_read_strobe_n,
    input wire logic        o_ext_write_strobe_n,
    input wire logic        o_ext_access_select_n,
    input wire logic [3:0]  o_window_select_n,
    input wire logic [3:0]  o_port_addr_lsb
);
    // ----------------------------------------------------------------
    // Decode relations
    // ----------------------------------------------------------------
    logic go, win, ext_hi, oth_hi;
    assign go = o_cpu_run && (i_read || i_write);
    assign win = go && (i_addr[19:13] == 7'h3F);
    assign ext_hi = &{o_ext_read_strobe_n, o_ext_write_strobe_n, o_ext_access_select_n, o_window_select_n};
    assign oth_hi = ext_hi && o_ram_read_select_n && o_ram_write_select_n;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    AST_IDLE_HIGH: assert property (!go |=> oth_hi && o_boot_rom_select_n)
        else $error("select active without an access");
    AST_BOOT_READ: assert property (go && i_read && i_addr[19:16] == 4'h0 |=> !o_boot_rom_select_n && oth_hi)
        else $error("boot read decode wrong");
    AST_RAM_MIRROR: assert property (go && i_read && i_addr[19:15] == 5'h03 |=> !o_ram_read_select_n)
        else $error("upper RAM copy not decoded");
    AST_RAM_RW: assert property (go && i_addr[19:16] == 4'h1 |=>
        o_ram_read_select_n == !$past(i_read) && o_ram_write_select_n == !$past(i_write))
        else $error("RAM select direction wrong");
    AST_WIN_AB: assert property (win && !i_addr[12] |=>
        o_window_select_n == {2'b11, ($past(i_addr[11]) ? 2'b01 : 2'b10)})
        else $error("window A or B select wrong");
    AST_WIN_CD: assert property (win && i_addr[12] |=>
        o_window_select_n == {($past(i_addr[11]) ? 2'b01 : 2'b10), 2'b11})
        else $error("window C or D select wrong");
    AST_EXT_STROBE: assert property (win |=> !o_ext_access_select_n &&
        o_ext_read_strobe_n == !$past(i_read) && o_ext_write_strobe_n == !$past(i_write))
        else $error("external strobes wrong");
    AST_UNUSED: assert property (go && i_addr[19:17] != 3'h0 && !win |=> ext_hi)
        else $error("external select on unused range");
    AST_ADDR_LSB: assert property (win |=> o_port_addr_lsb == $past(i_addr[3:0]))
        else $error("port address bits wrong");
    // Lock passes two synchroniser flops first, so it must be old news.
    AST_LOCK_FIRST: assert property ($rose(o_cpu_run) |-> $past(i_pll_lock, 2))
        else $error("run before lock");
endmodule : cs_decoder_checker
bind module_chip_select_decoder cs_decoder_checker u_chk (.i_sys_clk, .i_sys_rst, .i_addr, .i_read,
    .i_write, .i_pll_lock, .o_cpu_run, .o_boot_rom_select_n, .o_ram_read_select_n, .o_ram_write_select_n,
    .o_ext_read_strobe_n, .o_ext_write_strobe_n, .o_ext_access_select_n, .o_window_select_n, .o_port_addr_lsb);

// *** tb/eval_board_model.sv ***
// Plug-in board answering reads on the external 8-bit port.
`timescale 1ns/100ps
module eval_board_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_read_strobe_n,
    input  wire logic [3:0] i_window_select_n,
    input  wire logic [3:0] i_addr_lsb,
    output logic      [7:0] o_data
);
    // ----------------------------------------------------------------
    // Data drive
    // ----------------------------------------------------------------
    logic [7:0] last_q = 8'h00;
    // A released bus has no keeper, so it shows a changing pattern.
    always_comb begin
        if (!i_read_strobe_n && i_window_select_n != 4'hF) begin
            o_data = {i_window_select_n, i_addr_lsb};
        end else begin
            o_data = ~last_q;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        last_q <= o_data;
    end
endmodule : eval_board_model

// *** tb/tb.sv ***
// Self-checking bench of the chip-select decoder.
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    // ----------------------------------------------------------------
    // Stimulus and checks
    // ----------------------------------------------------------------
    logic i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_read = 1'b0, i_write = 1'b0, i_pll_lock = 1'b0;
    logic i_button_n = 1'b1, i_data0_strap = 1'b0, i_clk_double = 1'b0, i_test_done = 1'b0, i_test_pass = 1'b1;
    logic [19:0] i_addr = 20'h0_0000;
    logic [7:0] i_cpu_wdata = 8'h00, i_port_data, o_port_data_lsb, o_cpu_rdata;
    logic o_boot_rom_select_n, o_ram_read_select_n, o_ram_write_select_n, o_ext_read_strobe_n;
    logic o_ext_write_strobe_n, o_ext_access_select_n, o_port_data_oe, o_cpu_run, o_boot_8bit, o_sup_reset, o_led;
    logic [3:0] o_window_select_n, o_port_addr_lsb;
    logic [9:0] o_clk_mult;
    int n_mismatch = 0, tests_run = 0;
    cs_decoder_pkg::selects_s sel;
    logic [19:0] amap [18] = '{20'h0_0000, 20'h0_0010, 20'h0_8123, 20'h1_7FFF, 20'h1_8004, 20'h1_0000,
        20'h7_E000, 20'h7_E7FF, 20'h7_E800, 20'h7_EFFF, 20'h7_F000, 20'h7_F7FF, 20'h7_F800, 20'h7_FFFF,
        20'h2_0000, 20'h7_DFFF, 20'hF_FA00, 20'h8_0000};
    assign sel = {o_boot_rom_select_n, o_ram_read_select_n, o_ram_write_select_n, o_ext_read_strobe_n,
        o_ext_write_strobe_n, o_ext_access_select_n, o_window_select_n};
    module_chip_select_decoder DUT (.i_sys_clk, .i_sys_rst, .i_addr, .i_read, .i_write, .i_cpu_wdata,
        .i_port_data, .i_pll_lock, .i_button_n, .i_data0_strap, .i_clk_double, .i_test_done, .i_test_pass,
        .o_boot_rom_select_n, .o_ram_read_select_n, .o_ram_write_select_n, .o_ext_read_strobe_n,
        .o_ext_write_strobe_n, .o_ext_access_select_n, .o_window_select_n, .o_port_addr_lsb,
        .o_port_data_lsb, .o_port_data_oe, .o_cpu_rdata, .o_cpu_run, .o_boot_8bit, .o_clk_mult,
        .o_sup_reset, .o_led);
    eval_board_model u_board (.i_sys_clk, .i_read_strobe_n(o_ext_read_strobe_n),
        .i_window_select_n(o_window_select_n), .i_addr_lsb(o_port_addr_lsb), .o_data(i_port_data));
    always #25 i_sys_clk = ~i_sys_clk;
    task step;
        @(posedge i_sys_clk);
        #1;
    endtask : step
    function automatic cs_decoder_pkg::selects_s exp_sel(input logic [19:0] a, input logic r, input logic w);
        cs_decoder_pkg::selects_s e;
        e = '1;
        if (a[19:16] == 4'h0) e.boot_rom_select_n = !r;
        if (a[19:16] == 4'h1) e.ram_read_select_n = !r;
        if (a[19:16] == 4'h1) e.ram_write_select_n = !w;
        if (a[19:13] == 7'h3F) begin
            e.ext_read_strobe_n = !r;
            e.ext_write_strobe_n = !w;
            e.ext_access_select_n = 1'b0;
            e.window_select_n[a[12:11]] = 1'b0;
        end
        return e;
    endfunction : exp_sel
    task wait_run;
        for (int k = 0; k < 40 && o_cpu_run !== 1'b1; k++) step();
        `CHK(o_cpu_run, 1'b1)
    endtask : wait_run
    // Before lock every access is refused and the selects stay high.
    task t_startup;
        step();
        `CHK(o_clk_mult, 10'h100)
        `CHK(o_sup_reset, 1'b1)
        i_addr = 20'h7_E000;
        i_read = 1'b1;
        repeat (40) step();
        `CHK({o_cpu_run, sel}, 11'h3FF)
        // The strap is synchronised, so the width shows only from the third cycle of the pulse.
        `CHK(o_boot_8bit, 1'b1)
        i_read = 1'b0;
        i_pll_lock = 1'b1;
        wait_run();
    endtask : t_startup
    // Table walk, back to back, reads on even rows and writes on odd rows.
    task t_decode;
        for (int k = 0; k < 18; k++) begin
            i_addr = amap[k];
            i_read = !k[0];
            i_write = k[0];
            step();
            `CHK(sel, exp_sel(amap[k], !k[0], k[0]))
        end
        i_write = 1'b0;
        step();
        `CHK(sel, 10'h3FF)
    endtask : t_decode
    task t_port;
        i_addr = 20'h7_F805;
        i_read = 1'b1;
        step();
        step();
        `CHK({o_cpu_rdata, o_port_addr_lsb}, 12'h755)
        i_read = 1'b0;
        i_write = 1'b1;
        i_cpu_wdata = 8'hC3;
        step();
        `CHK({o_port_data_oe, o_port_data_lsb}, 9'h1C3)
        i_write = 1'b0;
        step();
        `CHK(o_port_data_oe, 1'b0)
    endtask : t_port
    task t_misc;
        `CHK(o_led, 1'b1)
        i_test_done = 1'b1;
        i_clk_double = 1'b1;
        repeat (3) step();
        `CHK(o_clk_mult, 10'h200)
        `CHK(o_led, 1'b1)
        i_data0_strap = 1'b1;
        i_button_n = 1'b0;
        repeat (2) step();
        i_button_n = 1'b1;
        for (int k = 0; k < 8 && o_sup_reset !== 1'b1; k++) step();
        `CHK(o_sup_reset, 1'b1)
        step();
        `CHK(o_clk_mult, 10'h100)
        `CHK(o_cpu_run, 1'b0)
        wait_run();
        `CHK(o_boot_8bit, 1'b0)
    endtask : t_misc
    task wrap_up;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // The tests need about 115 cycles, so 2000 means a hang.
    initial begin
        #(50 * 2000);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge i_sys_clk);
        #1;
        i_sys_rst = 1'b0;
        t_startup();
        t_decode();
        t_port();
        t_misc();
        wrap_up();
    end
endmodule : tb
